//--- src/drf_refresh_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "drf_defs.svh"
// How it works
// - every cell refreshed within each 2 ms
// - refresh drives 7-bit row and row strobe on the same clock
// - one row refresh every 16 us average
// - refresh hidden in last opcode fetch clocks
// - start refresh on dbin fall with fetch
// - refresh disables cpu mux, drives row count
// - refresh cycles give row strobe, no column
// - end pulse clears, releases, increments row
// - each refresh strobe outside a refresh starts one refresh
// - strobe edge latched until its refresh starts
// - watchdog forces refresh after 16 us idle
// - bus clock divided by four, ticks stage
// - after seventh tick, hold ready low
// - eighth tick starts forced refresh cycle
// - ready hold latched until end pulse
// - every cycle clears divider and stages
// - build option for 32 us forced refresh
// - dma strobes each produce row strobe
// - dma row strobe without board select
// - cycle window 200 ns, then end pulse
// - end pulse 50 ns blocks new cycles
module drf_refresh_ctrl
   import drf_pkg::*;
#(
   parameter bit SHORT_PERIOD = 1'b0
) (
   input  wire logic                  clk_sys,
   input  wire logic                  nrst,
   input  wire logic                  ce,
   input  wire drf_bus_s              bus,
   input  wire logic                  boardSelect,
   output logic                       rasN,
   output logic                       casN,
   output logic                       refresh_active,
   output logic                       cpuMuxOe,
   output logic                       refAddrOe,
   output logic [`DRF_ROW_W-1:0]      refRow,
   output logic                       readyPullOe,
   output logic                       endPulse
);

   drf_state_e             state_ff;
   drf_state_e             nxt_state;
   logic [`DRF_TMR_W-1:0]  tmr_ff;
   logic [`DRF_ROW_W-1:0]  row_ff;
   logic                   refreshActive_ff;
   logic                   nxt_refreshActive;
   logic                   memPend_ff;
   logic                   refPend_ff;
   logic                   waitLatch_ff;
   logic                   nxt_waitLatch;
   logic                   rasN_ff;
   logic                   casN_ff;
   logic                   cpuMuxOe_ff;
   logic                   refAddrOe_ff;
   logic                   readyPull_ff;
   logic                   endPulse_ff;

   logic busClkRise;
   logic dbinRise;
   logic dbinFall;
   logic strobeFall;
   logic wrFall;
   logic mwrtRise;
   logic memRdRise;
   logic wdHold;
   logic wdForce;
   logic memTrig;
   logic dmaTrig;
   logic refTrig;
   logic startMem;
   logic startRef;
   logic endStart;
   logic inWin;

   drf_edge #(.RISE(1'b1)) u_busClk (
      .clk_sys (clk_sys), .nrst (nrst), .ce (ce),
      .sig (bus.busClk), .pulse (busClkRise));
   drf_edge #(.RISE(1'b1)) u_dbinR (
      .clk_sys (clk_sys), .nrst (nrst), .ce (ce),
      .sig (bus.dbin), .pulse (dbinRise));
   drf_edge #(.RISE(1'b0)) u_dbinF (
      .clk_sys (clk_sys), .nrst (nrst), .ce (ce),
      .sig (bus.dbin), .pulse (dbinFall));
   drf_edge #(.RISE(1'b0)) u_strobe (
      .clk_sys (clk_sys), .nrst (nrst), .ce (ce),
      .sig (bus.refreshStrobeN), .pulse (strobeFall));
   drf_edge #(.RISE(1'b0)) u_wr (
      .clk_sys (clk_sys), .nrst (nrst), .ce (ce),
      .sig (bus.wrN), .pulse (wrFall));
   drf_edge #(.RISE(1'b1)) u_mwrt (
      .clk_sys (clk_sys), .nrst (nrst), .ce (ce),
      .sig (bus.mwrt), .pulse (mwrtRise));
   drf_edge #(.RISE(1'b1)) u_memRd (
      .clk_sys (clk_sys), .nrst (nrst), .ce (ce),
      .sig (bus.memRd), .pulse (memRdRise));

   drf_refresh_timer #(.SHORT_PERIOD(SHORT_PERIOD)) u_timer (
      .clk_sys    (clk_sys),
      .nrst       (nrst),
      .ce         (ce),
      .busClkRise (busClkRise),
      .clr        (inWin),
      .holdReq    (wdHold),
      .forceReq   (wdForce)
   );

   assign inWin = (state_ff == ST_WIN);
   // dma traffic starts a row strobe whatever the board select says
   assign dmaTrig = dbinRise & bus.hlda;
   assign memTrig = wrFall | mwrtRise | memRdRise | dmaTrig;
   assign refTrig = (dbinFall & bus.opcodeFetchCycle)
                  | strobeFall
                  | wdForce;
   // memory first: a waiting refresh follows right after its end pulse
   assign startMem = (state_ff == ST_IDLE) & memPend_ff;
   assign startRef = (state_ff == ST_IDLE) & ~memPend_ff & refPend_ff;
   assign endStart = inWin & (tmr_ff == `DRF_WIN_LAST);

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (memPend_ff || refPend_ff) begin
               nxt_state = ST_WIN;
            end
         end
         ST_WIN: begin
            if (endStart) begin
               nxt_state = ST_END;
            end
         end
         ST_END: begin
            if (tmr_ff == `DRF_END_LAST) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_ff <= ST_IDLE;
         tmr_ff   <= `DRF_TMR_ZERO;
      end else if (ce) begin
         state_ff <= nxt_state;
         tmr_ff   <= (nxt_state != state_ff) ? `DRF_TMR_ZERO
                                             : tmr_ff + `DRF_TMR_ONE;
      end
   end

   // pending latches: a new trigger beats the clear in the same cycle
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         memPend_ff <= 1'b0;
         refPend_ff <= 1'b0;
      end else if (ce) begin
         memPend_ff <= memTrig | (memPend_ff & ~startMem);
         refPend_ff <= (refTrig & ~refreshActive_ff)
                     | (refPend_ff & ~startRef);
      end
   end

   assign nxt_refreshActive = startRef | (refreshActive_ff & ~endStart);
   assign nxt_waitLatch     = wdHold | (waitLatch_ff & ~endStart);

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         refreshActive_ff <= 1'b0;
         waitLatch_ff     <= 1'b0;
      end else if (ce) begin
         refreshActive_ff <= nxt_refreshActive;
         waitLatch_ff     <= nxt_waitLatch;
      end
   end

   // row start value is free; reset only keeps simulation clean
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         row_ff <= `DRF_ROW_RST;
      end else if (ce && endStart && refreshActive_ff) begin
         row_ff <= row_ff + `DRF_ROW_ONE;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rasN_ff      <= 1'b1;
         casN_ff      <= 1'b1;
         cpuMuxOe_ff  <= 1'b1;
         refAddrOe_ff <= 1'b0;
         readyPull_ff <= 1'b0;
         endPulse_ff  <= 1'b0;
      end else if (ce) begin
         rasN_ff      <= ~(nxt_state == ST_WIN);
         casN_ff      <= ~((nxt_state == ST_WIN) & boardSelect
                           & ~nxt_refreshActive);
         cpuMuxOe_ff  <= ~nxt_refreshActive;
         refAddrOe_ff <= nxt_refreshActive;
         readyPull_ff <= nxt_waitLatch | wdHold;
         endPulse_ff  <= (nxt_state == ST_END);
      end
   end

   assign rasN           = rasN_ff;
   assign casN           = casN_ff;
   assign refresh_active = refreshActive_ff;
   assign cpuMuxOe       = cpuMuxOe_ff;
   assign refAddrOe      = refAddrOe_ff;
   assign refRow         = row_ff;
   assign readyPullOe    = readyPull_ff;
   assign endPulse       = endPulse_ff;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst || !ce);

   property p_no_cas_refresh;
      refreshActive_ff |-> casN_ff;
   endproperty
   a_no_cas_refresh: assert property (p_no_cas_refresh)
      else $error("column strobe during refresh");

   property p_addr_swap;
      refreshActive_ff |-> (refAddrOe_ff && !cpuMuxOe_ff);
   endproperty
   a_addr_swap: assert property (p_addr_swap)
      else $error("refresh address not driven during refresh");

   property p_row_step;
      $fell(refreshActive_ff) |-> (row_ff == $past(row_ff) + `DRF_ROW_ONE);
   endproperty
   a_row_step: assert property (p_row_step)
      else $error("row counter did not step by one");

   property p_ras_min;
      $fell(rasN_ff) |-> !rasN_ff [*8];
   endproperty
   a_ras_min: assert property (p_ras_min)
      else $error("row strobe window too short");

   property p_ras_end;
      $fell(rasN_ff) |-> ##[1:60] $rose(rasN_ff);
   endproperty
   a_ras_end: assert property (p_ras_end)
      else $error("row strobe window did not end");

   property p_end_gap;
      $rose(rasN_ff) |-> (rasN_ff && endPulse_ff) [*8];
   endproperty
   a_end_gap: assert property (p_end_gap)
      else $error("new cycle inside end pulse");

   property p_wait_held;
      waitLatch_ff |-> readyPull_ff;
   endproperty
   a_wait_held: assert property (p_wait_held)
      else $error("ready released while wait latched");

   property p_force_runs;
      wdForce |-> ##[1:200] refreshActive_ff;
   endproperty
   a_force_runs: assert property (p_force_runs)
      else $error("forced refresh did not start");

   property p_wd_clear;
      inWin ##1 ce |-> !wdForce;
   endproperty
   a_wd_clear: assert property (p_wd_clear)
      else $error("watchdog not cleared by cycle");

   property p_dma_ras;
      dmaTrig |-> ##[1:200] !rasN_ff;
   endproperty
   a_dma_ras: assert property (p_dma_ras)
      else $error("dma strobe gave no row strobe");

   property p_strobe_ref;
      strobeFall && !refreshActive_ff |-> ##[1:200] refreshActive_ff;
   endproperty
   a_strobe_ref: assert property (p_strobe_ref)
      else $error("refresh strobe lost");

   property p_cov_strobe;
      strobeFall ##[1:100] $rose(refreshActive_ff);
   endproperty
   c_cov_strobe: cover property (p_cov_strobe);

   property p_cov_force;
      wdForce ##[1:100] $fell(refreshActive_ff);
   endproperty
   c_cov_force: cover property (p_cov_force);

   property p_cov_dma;
      dmaTrig && !boardSelect ##[1:10] $fell(rasN_ff);
   endproperty
   c_cov_dma: cover property (p_cov_dma);

endmodule // drf_refresh_ctrl
`default_nettype wire

//--- src/drf_defs.svh
`ifndef DRF_DEFS_SVH
`define DRF_DEFS_SVH

// timing of the fabric clock and of the shared cycle timer
`define DRF_CLK_NS       5
`define DRF_WIN_NS       200
`define DRF_WIN_CYC      ((`DRF_WIN_NS + `DRF_CLK_NS - 1) / `DRF_CLK_NS)
`define DRF_END_NS       50
`define DRF_END_CYC      ((`DRF_END_NS + `DRF_CLK_NS - 1) / `DRF_CLK_NS)
`define DRF_TMR_W        6
`define DRF_WIN_LAST     (`DRF_TMR_W'(`DRF_WIN_CYC - 1))
`define DRF_END_LAST     (`DRF_TMR_W'(`DRF_END_CYC - 1))
`define DRF_TMR_ZERO     (`DRF_TMR_W'(0))
`define DRF_TMR_ONE      (`DRF_TMR_W'(1))

// refresh row counter
`define DRF_ROW_W        7
`define DRF_ROW_RST      7'h00
`define DRF_ROW_ONE      7'h01

// watchdog: bus clock divider taps and stage counter
`define DRF_DIV_W        3
`define DRF_DIV_RST      3'h0
`define DRF_DIV_ONE      3'h1
`define DRF_TAP_DIV4     1
`define DRF_TAP_DIV8     2
`define DRF_STG_W        4
`define DRF_STG_RST      4'h0
`define DRF_STG_ONE      4'h1
`define DRF_STG_HOLD     4'h7
`define DRF_STG_FORCE    4'h8

`endif

//--- src/drf_pkg.sv
package drf_pkg;

   // bus-side inputs, all sampled on clk_sys
   typedef struct packed {
      logic busClk;
      logic dbin;
      logic opcodeFetchCycle;
      logic refreshStrobeN;
      logic hlda;
      logic wrN;
      logic mwrt;
      logic memRd;
   } drf_bus_s;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WIN  = 2'b01,
      ST_END  = 2'b11
   } drf_state_e;

endpackage : drf_pkg

//--- src/drf_edge.sv
`timescale 1ns/1ps
`default_nettype none
module drf_edge #(
   parameter bit RISE = 1'b1
) (
   input  wire logic clk_sys,
   input  wire logic nrst,
   input  wire logic ce,
   input  wire logic sig,
   output logic      pulse
);

   logic prev_ff;
   logic armed_ff;

   // no edge until one sample is taken after reset, so a pin resting
   // away from the assumed level cannot fake an edge at release
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         prev_ff  <= RISE ? 1'b0 : 1'b1;
         armed_ff <= 1'b0;
      end else if (ce) begin
         prev_ff  <= sig;
         armed_ff <= 1'b1;
      end
   end

   assign pulse = ce & armed_ff
                & (RISE ? (sig & ~prev_ff) : (~sig & prev_ff));

endmodule // drf_edge
`default_nettype wire

//--- src/drf_refresh_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "drf_defs.svh"
module drf_refresh_timer #(
   parameter bit SHORT_PERIOD = 1'b0
) (
   input  wire logic clk_sys,
   input  wire logic nrst,
   input  wire logic ce,
   input  wire logic busClkRise,
   input  wire logic clr,
   output logic      holdReq,
   output logic      forceReq
);

   localparam int TAP = SHORT_PERIOD ? `DRF_TAP_DIV8 : `DRF_TAP_DIV4;

   logic [`DRF_DIV_W-1:0] div_ff;
   logic [`DRF_DIV_W-1:0] nxt_div;
   logic [`DRF_STG_W-1:0] stage_ff;
   logic                  tick;

   assign nxt_div = div_ff + `DRF_DIV_ONE;
   // tick on the rising edge of the chosen divider tap
   assign tick = busClkRise & nxt_div[TAP] & ~div_ff[TAP];

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         div_ff <= `DRF_DIV_RST;
      end else if (ce) begin
         if (clr) begin
            div_ff <= `DRF_DIV_RST;
         end else if (busClkRise) begin
            div_ff <= nxt_div;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         stage_ff <= `DRF_STG_RST;
      end else if (ce) begin
         if (clr) begin
            stage_ff <= `DRF_STG_RST;
         end else if (tick && stage_ff != `DRF_STG_FORCE) begin
            stage_ff <= stage_ff + `DRF_STG_ONE;
         end
      end
   end

   // hold off only once the tick clock is low again after tick seven
   assign holdReq = (stage_ff == `DRF_STG_HOLD && !div_ff[TAP])
                  | (stage_ff == `DRF_STG_FORCE);
   assign forceReq = ce & ~clr & tick & (stage_ff == `DRF_STG_HOLD);

endmodule // drf_refresh_timer
`default_nettype wire

//--- verif/drf_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module drf_bus_master
   import drf_pkg::*;
(
   input  wire logic     clk_sys,
   output var  drf_bus_s bus
);
   localparam drf_bus_s IDLE = '{busClk: 1'b0, dbin: 1'b0,
      opcodeFetchCycle: 1'b0, refreshStrobeN: 1'b1, hlda: 1'b0,
      wrN: 1'b1, mwrt: 1'b0, memRd: 1'b0};

   drf_bus_s sig = IDLE;
   logic     bclk = 1'b0;
   int       phase = 0;

   // the bus clock is the system timing reference and runs free
   always @(posedge clk_sys) begin
      if (phase == 49) begin
         phase <= 0;
         bclk <= ~bclk;
      end else begin
         phase <= phase + 1;
      end
   end

   always_comb begin
      bus = sig;
      bus.busClk = bclk;
   end

   task automatic idle();
      @(posedge clk_sys);
      #1;
      sig = IDLE;
   endtask

   // applies one trigger; a fetch dbin pulse ends inside, the others stand until idle is called
   task automatic act(input int k, input logic fetch);
      @(posedge clk_sys);
      #1;
      case (k)
         0: sig.refreshStrobeN = 1'b0;
         1: begin
            sig.opcodeFetchCycle = fetch;
            sig.dbin = 1'b1;
            repeat (3) @(posedge clk_sys);
            #1;
            sig.dbin = 1'b0;
         end
         2: sig.wrN = 1'b0;
         3: sig.mwrt = 1'b1;
         4: sig.memRd = 1'b1;
         default: begin
            sig.hlda = 1'b1;
            sig.dbin = 1'b1;
         end
      endcase
   endtask
endmodule // drf_bus_master
`default_nettype wire

//--- verif/test_dram_refresh_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "drf_defs.svh"
module test_dram_refresh_control;
   logic                  clk_sys = 1'b0;
   logic                  nrst;
   logic                  ce;
   logic                  boardSelect;
   drf_pkg::drf_bus_s     bus;
   logic                  rasN;
   logic                  casN;
   logic                  refresh_active;
   logic                  cpuMuxOe;
   logic                  refAddrOe;
   logic                  readyPullOe;
   logic                  endPulse;
   logic [`DRF_ROW_W-1:0] refRow;
   int                    n_fail = 0;
   int                    tests_run = 0;
   int                    cycles = 0;
   localparam int         TIMEOUT = 16000;

   always #2.5 clk_sys = ~clk_sys;

   drf_bus_master i_drf_bus_master (.clk_sys(clk_sys), .bus(bus));

   drf_refresh_ctrl i_drf_refresh_ctrl (
      .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .bus(bus),
      .boardSelect(boardSelect), .rasN(rasN), .casN(casN),
      .refresh_active(refresh_active), .cpuMuxOe(cpuMuxOe),
      .refAddrOe(refAddrOe), .refRow(refRow),
      .readyPullOe(readyPullOe), .endPulse(endPulse));

   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      if (n_fail == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == TIMEOUT) begin
         n_fail++;
         report_and_stop();
      end
   end

   task automatic tick();
      @(posedge clk_sys);
      #1;
   endtask

   function automatic logic [7:0] outs();
      return {rasN, casN, refresh_active, cpuMuxOe, refAddrOe,
              readyPullOe, endPulse, 1'b0};
   endfunction

   // one triggered cycle, judged from start to the end of its clear pulse
   task automatic run_cycle(input int k, input logic fetch, input logic bs,
                            input logic expRef, input logic expCas);
      logic [6:0] row;
      int         n;
      row = refRow + 7'(expRef);
      boardSelect = bs;
      i_drf_bus_master.act(k, fetch);
      i_drf_bus_master.idle();
      n = 0;
      while (rasN !== 1'b0 && n < 6) begin
         tick();
         n++;
      end
      check("ras start", 8'(rasN), 8'h00);
      check("cas", 8'(casN), {7'h00, ~expCas});
      check("refresh", 8'(refresh_active), 8'(expRef));
      check("ref addr", 8'(refAddrOe), 8'(expRef));
      check("cpu mux", 8'(cpuMuxOe), {7'h00, ~expRef});
      n = 0;
      while (rasN === 1'b0 && n < 60) begin
         tick();
         n++;
      end
      check("ras width", 8'(n), 8'h28);
      check("end pulse", 8'(endPulse), 8'h01);
      check("row", 8'(refRow), 8'(row));
      check("end outs", outs() & 8'h38, 8'h10);
      n = 0;
      while (endPulse === 1'b1 && n < 20) begin
         tick();
         n++;
      end
      check("end width", 8'(n), 8'h0a);
   endtask

   task automatic t_fetch();
      logic [6:0] row;
      run_cycle(1, 1'b1, 1'b1, 1'b1, 1'b0);
      row = refRow;
      i_drf_bus_master.act(1, 1'b0);
      i_drf_bus_master.idle();
      repeat (6) tick();
      check("no fetch ras", 8'(rasN), 8'h01);
      check("no fetch row", 8'(refRow), 8'(row));
   endtask

   // every row in turn, wrapping back to the first
   task automatic t_strobe();
      logic [6:0] row;
      row = refRow;
      for (int i = 0; i < 128; i++) begin
         run_cycle(0, 1'b0, 1'(i), 1'b1, 1'b0);
      end
      check("all rows", 8'(refRow), 8'(row));
   endtask

   task automatic t_dma();
      for (int k = 2; k < 6; k++) begin
         run_cycle(k, 1'b0, 1'(k + 1), 1'b0, 1'(k + 1));
      end
   endtask

   // with clock enable low the cycle must stand still, then finish
   task automatic t_freeze();
      int n;
      i_drf_bus_master.act(0, 1'b0);
      i_drf_bus_master.idle();
      repeat (5) tick();
      ce = 1'b0;
      repeat (50) tick();
      check("frozen", outs(), 8'h68);
      ce = 1'b1;
      n = 0;
      while (rasN === 1'b0 && n < 60) begin
         tick();
         n++;
      end
      check("frozen width", 8'(n), 8'h24);
      repeat (12) tick();
   endtask

   task automatic t_merge();
      logic [6:0] row;
      row = refRow + 7'h01;
      i_drf_bus_master.act(0, 1'b0);
      i_drf_bus_master.idle();
      repeat (8) tick();
      i_drf_bus_master.act(0, 1'b0);
      i_drf_bus_master.idle();
      i_drf_bus_master.act(1, 1'b1);
      i_drf_bus_master.idle();
      repeat (80) tick();
      check("merged row", 8'(refRow), 8'(row));
      check("merged idle", 8'(rasN), 8'h01);
   endtask

   task automatic t_watchdog();
      logic [6:0] row;
      int         n;
      int         h;
      int         tR;
      int         tF;
      // a memory cycle some 10 us into the idle time must restart the timer
      repeat (2000) tick();
      run_cycle(2, 1'b0, 1'b0, 1'b0, 1'b0);
      row = refRow + 7'h01;
      tR = 0;
      tF = 0;
      for (n = 1; n < 3400 && tF == 0; n++) begin
         tick();
         if (readyPullOe === 1'b1 && tR == 0) tR = n;
         if (refresh_active === 1'b1) tF = n;
      end
      check("hold time", 8'(tR >= 2400 && tR <= 2900), 8'h01);
      check("force time", 8'(tF >= 2800 && tF <= 3100), 8'h01);
      check("force outs", outs(), 8'h6c);
      n = 0;
      h = 0;
      while (rasN === 1'b0 && n < 60) begin
         h += 32'(readyPullOe === 1'b1);
         tick();
         n++;
      end
      check("hold width", 8'(h), 8'h28);
      tick();
      check("hold clear", 8'(readyPullOe), 8'h00);
      check("force row", 8'(refRow), 8'(row));
      repeat (10) tick();
   endtask

   task automatic t_midreset();
      i_drf_bus_master.act(0, 1'b0);
      i_drf_bus_master.idle();
      repeat (5) tick();
      nrst = 1'b0;
      tick();
      check("mid reset", outs(), 8'hd0);
      nrst = 1'b1;
      repeat (3) tick();
      check("after reset", outs(), 8'hd0);
   endtask

   initial begin
      nrst = 1'b0;
      ce = 1'b1;
      boardSelect = 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      check("reset", outs(), 8'hd0);
      nrst = 1'b1;
      tick();
      check("release", outs(), 8'hd0);
      t_fetch();
      t_strobe();
      t_dma();
      t_merge();
      t_freeze();
      t_watchdog();
      t_midreset();
      report_and_stop();
   end
endmodule // test_dram_refresh_control
`default_nettype wire
